// ### src/line_sync_map.svh
// Register offsets, field positions and reset values of the line-mode and sync block
// Contract
// - Line-mode bit 0 selects normal (0) or line-by-line colour (1) operation.
// - Line-by-line forces single-channel select to 1 and mono channel to 00.
// - Line-by-line disables green and blue gain amplifiers to save power.
// - Auto-cycle-or-clamp bit 1 matters only in line-by-line mode.
// - Bit 1 at 0: shared pin is clamp input, muxes selected internally.
// - Bit 1 at 1: colour auto-cycles on pulses of the shared pin.
// - While auto-cycling, the shared pin never drives reset level clamping.
// - Internal clamp bit 3 counts only in line-by-line with auto-cycling.
// - Force bit 2 in line-by-line makes input mux follow forced colour.
// - Internal colour field 5:4 decodes 00 red, 01 green, 10 blue.
// - Forced colour field 7:6 decodes 00 red, 01 green, 10 blue.
// - Sync detect bit 0 at 0 passes the sample pin straight through.
// - Sync detect at 1 turns a sample pin edge into an internal pulse.
// - Sync delay field 3:1 has no effect while detection is off.
// - Internal pulse lags the edge by delay-field clock periods; resets 000.
// - Polarity bit 0 detects falling edges, 1 detects rising edges.
// - Any write to the auto-cycle reset location returns the counter to red.
`ifndef LINE_SYNC_MAP_SVH
`define LINE_SYNC_MAP_SVH

// Byte addresses on the register bus
`define ADDR_LINE_MODE   12'h000
`define ADDR_SYNC_DET    12'h004
`define ADDR_ACYC_RESET  12'h008
`define ADDR_STATUS      12'h00C
`define ADDR_BITS        12

// Line-mode field positions
`define LM_LINE_SEQ      0
`define LM_ACYC_SEL      1
`define LM_FORCE_EN      2
`define LM_CLAMP_INT     3
`define LM_INT_COL_LO    4
`define LM_FRC_COL_LO    6

// Sync-detect field positions
`define SD_ENABLE        0
`define SD_DELAY_LO      1
`define SD_POLARITY      4

// Reset values
`define LINE_MODE_RST    8'h00
`define SYNC_DET_RST     8'h00

// Colour codes
`define COL_RED          2'h0
`define COL_GREEN        2'h1
`define COL_BLUE         2'h2

`endif

// ### src/line_sync_pkg.sv
// Types shared by the line-mode and sync block
package line_sync_pkg;

    // Colour channel selection
    typedef enum logic [1:0] {
        COL_RED_E   = 2'h0,
        COL_GREEN_E = 2'h1,
        COL_BLUE_E  = 2'h2,
        COL_RSVD_E  = 2'h3
    } colour_t;

    // Multiplexer and clamp controls to the analogue chain
    typedef struct packed {
        logic [1:0] input_sel;
        logic [1:0] gain_sel;
        logic [1:0] offset_sel;
        logic       mono_force;
        logic [1:0] mono_channel;
        logic       green_pga_off;
        logic       blue_pga_off;
        logic       clamp_en;
    } mux_ctrl_t;

    // Sync detector states
    typedef enum logic [2:0] {
        SD_IDLE  = 3'b001,
        SD_WAIT  = 3'b010,
        SD_PULSE = 3'b100
    } sync_state_t;

    // Sync detector state
    typedef struct packed {
        sync_state_t state;
        logic [2:0]  count;
        logic        pin_d;
        logic        pulse;
    } sync_reg_t;

endpackage

// ### src/sync_detect.sv
// Sample-sync edge detector with programmable delay
`timescale 1ns/10ps
module sync_detect (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       enable_i,
    input  wire logic       polarity_i,
    input  wire logic [2:0] delay_i,
    // Synchronised sample pin
    input  wire logic       pin_i,
    // Timing pulse
    output logic            pulse_o
);

    line_sync_pkg::sync_reg_t s_r;
    line_sync_pkg::sync_reg_t s_nxt;
    logic                     edge_seen;

    // Edge of the chosen polarity
    assign edge_seen = polarity_i ? (pin_i & ~s_r.pin_d)
                                  : (~pin_i & s_r.pin_d);

    // Next state
    always_comb begin
        s_nxt       = s_r;
        s_nxt.pin_d = pin_i;
        s_nxt.pulse = 1'b0;
        case (s_r.state)
            line_sync_pkg::SD_IDLE: begin
                if (enable_i && edge_seen) begin
                    if (delay_i == 3'h0) begin
                        s_nxt.pulse = 1'b1;
                        s_nxt.state = line_sync_pkg::SD_PULSE;
                    end else begin
                        s_nxt.count = delay_i;
                        s_nxt.state = line_sync_pkg::SD_WAIT;
                    end
                end
            end
            line_sync_pkg::SD_WAIT: begin
                // Delay counted in master clock periods
                if (s_r.count == 3'h1) begin
                    s_nxt.pulse = 1'b1;
                    s_nxt.state = line_sync_pkg::SD_PULSE;
                end
                s_nxt.count = s_r.count - 3'h1;
            end
            line_sync_pkg::SD_PULSE: begin
                s_nxt.state = line_sync_pkg::SD_IDLE;
            end
            default: begin
                s_nxt.state = line_sync_pkg::SD_IDLE;
            end
        endcase
        // Disabling abandons any pending pulse
        if (!enable_i) begin
            s_nxt.state = line_sync_pkg::SD_IDLE;
            s_nxt.pulse = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '{state: line_sync_pkg::SD_IDLE, count: 3'h0, pin_d: 1'b0, pulse: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pulse_o = s_r.pulse;

endmodule

// ### src/line_sync_ctrl.sv
// Line-by-line colour control and sample-sync detect with APB register access
`timescale 1ns/10ps
`include "line_sync_map.svh"
module line_sync_ctrl (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pins from the timing controller
    input  wire logic        shared_clamp_cycle_pin_i,
    input  wire logic        video_sample_pin_i,
    // Analogue chain controls
    output logic      [1:0]  input_sel_o,
    output logic      [1:0]  gain_sel_o,
    output logic      [1:0]  offset_sel_o,
    output logic             mono_force_o,
    output logic      [1:0]  mono_channel_o,
    output logic             green_pga_off_o,
    output logic             blue_pga_off_o,
    output logic             clamp_en_o,
    output logic             timing_sample_o
);

    // Complete module state
    typedef struct packed {
        logic [7:0]              line_mode;
        logic [7:0]              sync_det;
        logic [1:0]              mono_channel;
        logic                    mono_select;
        logic [1:0]              cycle_colour;
        logic [1:0]              clamp_sync;
        logic [1:0]              sample_sync;
        logic                    clamp_pin_d;
        line_sync_pkg::mux_ctrl_t ctrl;
        logic                    timing;
        logic [31:0]             rdata;
        logic                    ready;
        logic                    slverr;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic   sync_pulse;

    // Map reserved colour code onto red so muxes never see an undefined select
    function automatic logic [1:0] colour_decode(input logic [1:0] code);
        case (code)
            `COL_GREEN: colour_decode = `COL_GREEN;
            `COL_BLUE:  colour_decode = `COL_BLUE;
            default:    colour_decode = `COL_RED;
        endcase
    endfunction

    // Step red, green, blue and back
    function automatic logic [1:0] colour_next(input logic [1:0] code);
        case (code)
            `COL_RED:   colour_next = `COL_GREEN;
            `COL_GREEN: colour_next = `COL_BLUE;
            default:    colour_next = `COL_RED;
        endcase
    endfunction

    // Sync detector runs on the synchronised sample pin
    sync_detect u_sync (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .enable_i   (st_r.sync_det[`SD_ENABLE]),
        .polarity_i (st_r.sync_det[`SD_POLARITY]),
        .delay_i    (st_r.sync_det[`SD_DELAY_LO +: 3]),
        .pin_i      (st_r.sample_sync[1]),
        .pulse_o    (sync_pulse)
    );

    // Next state
    always_comb begin
        logic       setup_wr;
        logic       access;
        logic       line_seq;
        logic       acyc;
        logic       force_en;
        logic       cycle_pulse;
        logic [1:0] int_col;
        logic [1:0] frc_col;
        logic [1:0] sel_col;
        setup_wr    = 1'b0;
        access      = 1'b0;
        line_seq    = 1'b0;
        acyc        = 1'b0;
        force_en    = 1'b0;
        cycle_pulse = 1'b0;
        int_col     = `COL_RED;
        frc_col     = `COL_RED;
        sel_col     = `COL_RED;
        st_nxt      = st_r;

        // Pin synchronisers: second stage is the only reader of the first
        st_nxt.clamp_sync  = {st_r.clamp_sync[0], shared_clamp_cycle_pin_i};
        st_nxt.sample_sync = {st_r.sample_sync[0], video_sample_pin_i};
        st_nxt.clamp_pin_d = st_r.clamp_sync[1];

        // APB: one wait state per access phase, answer registered one cycle after access starts
        access          = psel_i && penable_i && !st_r.ready;
        setup_wr        = access && pwrite_i;
        st_nxt.ready    = access;
        st_nxt.slverr   = 1'b0;
        st_nxt.rdata    = 32'h0000_0000;
        if (access) begin
            case (paddr_i)
                `ADDR_LINE_MODE: begin
                    if (setup_wr && pstrb_i[0]) begin
                        st_nxt.line_mode = pwdata_i[7:0];
                    end
                    st_nxt.rdata = {24'h00_0000, st_r.line_mode};
                end
                `ADDR_SYNC_DET: begin
                    if (setup_wr && pstrb_i[0]) begin
                        st_nxt.sync_det = pwdata_i[7:0];
                    end
                    st_nxt.rdata = {24'h00_0000, st_r.sync_det};
                end
                `ADDR_ACYC_RESET: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
                `ADDR_STATUS: begin
                    st_nxt.rdata = {28'h000_0000, st_r.ctrl.clamp_en, st_r.timing,
                                    st_r.cycle_colour};
                end
                default: begin
                    st_nxt.slverr = 1'b1;
                end
            endcase
        end

        // Decoded mode bits
        line_seq = st_r.line_mode[`LM_LINE_SEQ];
        acyc     = line_seq && st_r.line_mode[`LM_ACYC_SEL];
        force_en = line_seq && st_r.line_mode[`LM_FORCE_EN];
        int_col  = colour_decode(st_r.line_mode[`LM_INT_COL_LO +: 2]);
        frc_col  = colour_decode(st_r.line_mode[`LM_FRC_COL_LO +: 2]);

        // Auto-cycle on rising pin edge; a reset write wins over a pulse
        cycle_pulse = acyc && st_r.clamp_sync[1] && !st_r.clamp_pin_d;
        if (cycle_pulse) begin
            st_nxt.cycle_colour = colour_next(st_r.cycle_colour);
        end
        if (setup_wr && paddr_i == `ADDR_ACYC_RESET) begin
            st_nxt.cycle_colour = `COL_RED;
        end

        // Colour feeding gain and offset muxes
        sel_col = acyc ? st_r.cycle_colour : int_col;
        if (line_seq) begin
            st_nxt.ctrl.gain_sel   = sel_col;
            st_nxt.ctrl.offset_sel = sel_col;
            st_nxt.ctrl.input_sel  = force_en ? frc_col : sel_col;
        end else begin
            // Normal mode: single-channel choice drives all muxes
            st_nxt.ctrl.gain_sel   = st_r.mono_channel;
            st_nxt.ctrl.offset_sel = st_r.mono_channel;
            st_nxt.ctrl.input_sel  = st_r.mono_channel;
        end

        // Forced single-channel setup, reset-held single-channel values kept underneath
        st_nxt.ctrl.mono_force    = line_seq ? 1'b1 : st_r.mono_select;
        st_nxt.ctrl.mono_channel  = line_seq ? `COL_RED : st_r.mono_channel;
        st_nxt.ctrl.green_pga_off = line_seq;
        st_nxt.ctrl.blue_pga_off  = line_seq;

        // Clamp source: pin unless auto-cycling, then the internal bit
        if (acyc) begin
            st_nxt.ctrl.clamp_en = st_r.line_mode[`LM_CLAMP_INT];
        end else begin
            st_nxt.ctrl.clamp_en = st_r.clamp_sync[1];
        end

        // Timing output: raw pin or detected pulse; delay unused when raw
        if (st_r.sync_det[`SD_ENABLE]) begin
            st_nxt.timing = sync_pulse;
        end else begin
            st_nxt.timing = st_r.sample_sync[1];
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r              <= '0;
            st_r.line_mode    <= `LINE_MODE_RST;
            st_r.sync_det     <= `SYNC_DET_RST;
            st_r.cycle_colour <= `COL_RED;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata_o        = st_r.rdata;
    assign pready_o        = st_r.ready;
    assign pslverr_o       = st_r.slverr;
    assign input_sel_o     = st_r.ctrl.input_sel;
    assign gain_sel_o      = st_r.ctrl.gain_sel;
    assign offset_sel_o    = st_r.ctrl.offset_sel;
    assign mono_force_o    = st_r.ctrl.mono_force;
    assign mono_channel_o  = st_r.ctrl.mono_channel;
    assign green_pga_off_o = st_r.ctrl.green_pga_off;
    assign blue_pga_off_o  = st_r.ctrl.blue_pga_off;
    assign clamp_en_o      = st_r.ctrl.clamp_en;
    assign timing_sample_o = st_r.timing;

endmodule

// ### sim/line_sync_ctrl_assertions.sv
// Port checker of the line-mode and sync block
`timescale 1ns/10ps
module line_sync_ctrl_assertions (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        video_sample_pin_i,
    input wire logic [1:0]  input_sel_o,
    input wire logic [1:0]  gain_sel_o,
    input wire logic [1:0]  offset_sel_o,
    input wire logic        mono_force_o,
    input wire logic [1:0]  mono_channel_o,
    input wire logic        green_pga_off_o,
    input wire logic        blue_pga_off_o,
    input wire logic        clamp_en_o,
    input wire logic        timing_sample_o
);
    logic [7:0]  lm_r;
    logic [7:0]  sd_r;
    logic [3:0]  quiet_r;
    logic        pin_q_r;
    logic [11:0] hist_r;
    logic        edge_c;
    logic        ok_c;
    // Reserved colour code falls back to red
    function automatic logic [1:0] col(input logic [1:0] c);
        return (c == 2'h3) ? 2'h0 : c;
    endfunction
    // Outputs are judged only once a write has had time to land
    assign ok_c = (quiet_r > 4'h1) && !pready_o;
    assign edge_c = sd_r[4] ? (video_sample_pin_i && !pin_q_r) : (!video_sample_pin_i && pin_q_r);
    // Shadow of the setup registers and history of detected edges
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lm_r <= 8'h00;
            sd_r <= 8'h00;
            quiet_r <= 4'h0;
            pin_q_r <= 1'b0;
            hist_r <= 12'h000;
        end else begin
            pin_q_r <= video_sample_pin_i;
            hist_r <= {hist_r[10:0], edge_c};
            quiet_r <= (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
            if (pready_o && pwrite_i) begin
                quiet_r <= 4'h0;
            end
            if (pready_o && pwrite_i && pstrb_i[0] && paddr_i == 12'h000) lm_r <= pwdata_i[7:0];
            if (pready_o && pwrite_i && pstrb_i[0] && paddr_i == 12'h004) sd_r <= pwdata_i[7:0];
        end
    end

    // All checks run on the master clock and rest during reset
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // Bus answer lasts one cycle, error only rides on it
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");

    // Mode outputs against the shadow of the line-mode register
    a_normal_no_force: assert property (ok_c && !lm_r[0] |->
        !mono_force_o && !green_pga_off_o)
        else $error("normal mode shows line mode forcing");
    a_line_forces_mono: assert property (ok_c && lm_r[0] |->
        mono_force_o && mono_channel_o == 2'h0)
        else $error("single channel not forced in line mode");
    a_pga_follow_mode: assert property (ok_c |->
        green_pga_off_o == lm_r[0] && blue_pga_off_o == lm_r[0])
        else $error("gain amplifier disable does not follow mode");
    a_internal_colour: assert property (ok_c && lm_r[0] && !lm_r[1] |->
        gain_sel_o == col(lm_r[5:4]) && offset_sel_o == col(lm_r[5:4]))
        else $error("gain or offset mux off the internal colour");
    a_input_forced: assert property (ok_c && lm_r[0] && lm_r[2] |->
        input_sel_o == col(lm_r[7:6]))
        else $error("input mux off the forced colour");
    a_clamp_from_bit: assert property (ok_c && lm_r[0] && lm_r[1] |->
        clamp_en_o == lm_r[3])
        else $error("clamp does not follow the internal bit");

    // Timing output in pass-through and detect modes
    a_sync_passthru: assert property (ok_c && !sd_r[0] && quiet_r > 4'h3 |->
        timing_sample_o == $past(video_sample_pin_i, 3))
        else $error("pass-through timing off the sample pin");
    a_pulse_after_edge: assert property (ok_c && sd_r[0] && timing_sample_o |->
        hist_r[4'd3 + sd_r[3:1]])
        else $error("timing pulse without an edge at the set delay");
    a_pulse_one_cycle: assert property (ok_c && sd_r[0] && timing_sample_o |->
        ##1 !timing_sample_o)
        else $error("detected pulse longer than one cycle");

    // Main scenarios reached
    c_auto_cycle: cover property (ok_c && lm_r[0] && lm_r[1]);
    c_forced_input: cover property (ok_c && lm_r[0] && lm_r[2]);
    c_detect_pulse: cover property (sd_r[0] && timing_sample_o);
    c_bus_error: cover property (pslverr_o);
endmodule

// Checker rides along inside every instance of the block
bind line_sync_ctrl line_sync_ctrl_assertions i_chk (
    .ref_clk_i          (ref_clk_i),
    .rst_i              (rst_i),
    .pwrite_i           (pwrite_i),
    .paddr_i            (paddr_i),
    .pwdata_i           (pwdata_i),
    .pstrb_i            (pstrb_i),
    .pready_o           (pready_o),
    .pslverr_o          (pslverr_o),
    .psel_i             (psel_i),
    .penable_i          (penable_i),
    .video_sample_pin_i (video_sample_pin_i),
    .input_sel_o        (input_sel_o),
    .gain_sel_o         (gain_sel_o),
    .offset_sel_o       (offset_sel_o),
    .mono_force_o       (mono_force_o),
    .mono_channel_o     (mono_channel_o),
    .green_pga_off_o    (green_pga_off_o),
    .blue_pga_off_o     (blue_pga_off_o),
    .clamp_en_o         (clamp_en_o),
    .timing_sample_o    (timing_sample_o)
);

// ### sim/scan_timing_model.sv
// Scanner timing controller model driving the clamp/cycle and sample pins
`timescale 1ns/10ps
module scan_timing_model (
    input  wire logic ref_clk_i,
    output logic      shared_clamp_cycle_pin_o,
    output logic      video_sample_pin_o
);
    // Both pins idle low
    initial begin
        shared_clamp_cycle_pin_o = 1'b0;
        video_sample_pin_o = 1'b0;
    end
    // Cycle pulse, never shorter than two cycles each way for the pin sync
    task automatic cycle_pulse(input int hold);
        int h;
        h = (hold < 2) ? 2 : hold;
        @(posedge ref_clk_i);
        shared_clamp_cycle_pin_o <= 1'b1;
        repeat (h) @(posedge ref_clk_i);
        shared_clamp_cycle_pin_o <= 1'b0;
        repeat (h) @(posedge ref_clk_i);
    endtask
    // Level on the shared pin while it serves as clamp input
    task automatic set_clamp(input logic lvl);
        @(posedge ref_clk_i);
        shared_clamp_cycle_pin_o <= lvl;
    endtask
    // One high pulse of the sample pin, followed by an equal low gap
    task automatic sample_pulse(input int width);
        @(posedge ref_clk_i);
        video_sample_pin_o <= 1'b1;
        repeat (width) @(posedge ref_clk_i);
        video_sample_pin_o <= 1'b0;
        repeat (width) @(posedge ref_clk_i);
    endtask
endmodule

// ### sim/line_sync_ctrl_tb.sv
// Self-checking bench of the line-mode and sync block
`timescale 1ns/10ps
`include "line_sync_map.svh"
module line_sync_ctrl_tb;
    logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic        shared_clamp_cycle_pin_i, video_sample_pin_i, mono_force_o, clamp_en_o;
    logic        green_pga_off_o, blue_pga_off_o, timing_sample_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0]  pstrb_i;
    logic [1:0]  input_sel_o, gain_sel_o, offset_sel_o, mono_channel_o, ex;
    int          mismatches, n_checks, pulses;
    time         t0, hi_t;

    line_sync_ctrl i_dut (.*);
    scan_timing_model i_tmc (
        .ref_clk_i                (ref_clk_i),
        .shared_clamp_cycle_pin_o (shared_clamp_cycle_pin_i),
        .video_sample_pin_o       (video_sample_pin_i)
    );

    // 40 MHz master clock
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // Counts cycles with the timing output high and keeps the last one
    always @(posedge ref_clk_i) begin
        if (timing_sample_o === 1'b1) begin
            pulses++;
            hi_t = $time;
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // APB transfer; waits for pready under a bounded count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // Registered controls follow a write one edge after ready
        @(posedge ref_clk_i);
        if (n >= 20) begin
            mismatches++;
            complete_run();
        end
    endtask

    initial begin
        rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i} = 3'b000;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        pstrb_i = 4'h1;
        mismatches = 0;
        n_checks = 0;
        pulses = 0;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, `ADDR_LINE_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, `ADDR_SYNC_DET, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Mode bits without line-by-line leave everything on red
        apb(1'b1, `ADDR_LINE_MODE, 32'h0000_00FE);
        chk({mono_force_o, input_sel_o, gain_sel_o, offset_sel_o}, 32'h0000_0000);
        // Every internal and forced colour code, reserved one included
        for (int c = 0; c < 4; c++) begin
            ex = (c == 3) ? 2'h0 : 2'(c);
            apb(1'b1, `ADDR_LINE_MODE, 32'(c * 16 + 1));
            chk({input_sel_o, gain_sel_o, offset_sel_o}, {26'h0, ex, ex, ex});
            chk({mono_force_o, mono_channel_o, green_pga_off_o, blue_pga_off_o}, 32'h13);
            apb(1'b1, `ADDR_LINE_MODE, 32'(c * 64 + 16'h15));
            chk({input_sel_o, gain_sel_o}, {28'h0, ex, 2'h1});
        end
        // Shared pin acts as clamp input without auto-cycling
        apb(1'b1, `ADDR_LINE_MODE, 32'h0000_0001);
        i_tmc.set_clamp(1'b1);
        repeat (5) @(posedge ref_clk_i);
        chk(clamp_en_o, 32'h1);
        i_tmc.set_clamp(1'b0);
        repeat (5) @(posedge ref_clk_i);
        chk(clamp_en_o, 32'h0);
        // Auto-cycling with prompt and slow pulses; clamp from the bit only
        apb(1'b1, `ADDR_LINE_MODE, 32'h0000_000B);
        apb(1'b1, `ADDR_ACYC_RESET, 32'h0000_0000);
        chk(gain_sel_o, 32'h0);
        for (int k = 1; k <= 4; k++) begin
            i_tmc.cycle_pulse(k[0] ? 2 : 5);
            repeat (2) @(posedge ref_clk_i);
            chk({gain_sel_o, offset_sel_o}, 32'((k % 3) * 5));
            chk(clamp_en_o, 32'h1);
        end
        apb(1'b1, `ADDR_ACYC_RESET, 32'h0000_00A5);
        chk(gain_sel_o, 32'h0);
        apb(1'b1, `ADDR_LINE_MODE, 32'h0000_0003);
        chk(clamp_en_o, 32'h0);
        // Unmapped write is refused and changes nothing
        apb(1'b1, 12'h010, 32'h0000_00FF);
        chk(err, 32'h1);
        apb(1'b0, `ADDR_LINE_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        // Pass-through ignores the programmed delay
        apb(1'b1, `ADDR_SYNC_DET, 32'h0000_000E);
        pulses = 0;
        i_tmc.sample_pulse(3);
        repeat (8) @(posedge ref_clk_i);
        chk(pulses, 32'd3);
        // Detector: both polarities, shortest and longest delay
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 8; d += 7) begin
                apb(1'b1, `ADDR_SYNC_DET, 32'(p * 16 + d * 2 + 1));
                pulses = 0;
                t0 = $time;
                i_tmc.sample_pulse(4);
                repeat (14) @(posedge ref_clk_i);
                chk(pulses, 32'd1);
                chk(32'((hi_t - t0) / 25), 32'(6 + d + ((p == 0) ? 4 : 0)));
            end
        end
        complete_run();
    end
endmodule
